// file: rtl/host_port_pkg.sv
// Constants shared by the parallel host byte port and its output FIFO
`default_nettype none
package host_port_pkg;
  // Data path widths and output FIFO depth
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  // Control register field positions
  localparam int CTRL_W = 16;
  localparam int CTRL_WIDTH_BIT = 0;
  localparam int CTRL_STYLE_BIT = 1;
  localparam int CTRL_STROBE_POL_BIT = 2;
  localparam int CTRL_BSEL_POL_BIT = 3;
  localparam int CTRL_FLAG_POL_BIT = 4;
  localparam int CTRL_FLAG_OR_BIT = 5;
  localparam int CTRL_EMPTY_INV_BIT = 7;
  // Status byte field positions as seen on the data pins
  localparam int STAT_OEMPTY_BIT = 0;
  localparam int STAT_IFULL_BIT = 1;
  // Interrupt enable positions
  localparam int IRQ_IN_BIT = 0;
  localparam int IRQ_OUT_BIT = 1;
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] BUF_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic IFULL_RESET = 1'b0;
  localparam logic OEMPTY_RESET = 1'b1;
endpackage
`default_nettype wire

// file: rtl/host_fifo_if.sv
// Carrier between the host port and its output FIFO
`timescale 1ns/1ps
`default_nettype none
interface host_fifo_if #(
  parameter int WIDTH = 16
) ();
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  // FIFO side
  modport buffer (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
  // Port side
  modport user (output push_valid, output push_data, output pop_ready,
                input push_ready, input pop_valid, input pop_data);
endinterface
`default_nettype wire

// file: rtl/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Queue ports
  host_fifo_if.buffer q
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic full;
  logic empty;

  // Wrap bit tells full from empty; depth must be a power of two
  assign full = (st.wr_ptr[AW] != st.rd_ptr[AW]) && (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
  assign empty = st.wr_ptr == st.rd_ptr;
  assign q.push_ready = !full;
  assign q.pop_valid = !empty;
  assign q.pop_data = st.mem[st.rd_ptr[AW-1:0]];

  // Push and pop bookkeeping
  always_comb begin
    next_st = st;
    if (q.push_valid && !full) begin
      next_st.mem[st.wr_ptr[AW-1:0]] = q.push_data;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (q.pop_ready && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// file: rtl/host_parallel_port.sv
// Passive 8-bit parallel host port with 16-bit input and output buffers
`timescale 1ns/1ps
`default_nettype none
module host_parallel_port #(
  parameter int DATA_W = host_port_pkg::DATA_W,
  parameter int FIFO_DEPTH = host_port_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host strobes and selects
  input wire logic host_chip_select_n,
  input wire logic host_input_strobe_n,
  input wire logic host_output_strobe_n,
  input wire logic host_single_strobe,
  input wire logic host_read_write_n,
  input wire logic byte_select,
  input wire logic status_select,
  // Host data pins
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  // Flag pins
  output logic input_full_pin,
  output logic output_empty_pin,
  // Control register access from the core
  input wire logic ctrl_write,
  input wire logic [15:0] ctrl_wdata,
  output logic [15:0] ctrl_rdata,
  // Input buffer towards the core
  output logic core_in_valid,
  input wire logic core_in_ready,
  output logic [DATA_W-1:0] core_in_data,
  // Output words from the core
  input wire logic core_out_valid,
  output logic core_out_ready,
  input wire logic [DATA_W-1:0] core_out_data,
  // Core interrupts
  input wire logic [1:0] irq_enable,
  output logic input_strobe_irq,
  output logic output_strobe_irq
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [DATA_W-1:0] ibuf;
    logic [DATA_W-1:0] obuf;
    logic ifull;
    logic oempty;
    logic wr_prev;
    logic rd_prev;
    logic lat_status;
    logic lat_low;
    logic [7:0] lat_data;
    logic [7:0] pin_data;
    logic pin_oe_n;
    logic ifull_pin;
    logic oempty_pin;
    logic irq_in;
    logic irq_out;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  logic wide;
  logic style_rw;
  logic bsel_pol;
  logic strobe_on;
  logic wr_act;
  logic rd_act;
  logic lane_low;
  logic wr_done;
  logic rd_done;
  logic last_byte;
  logic data_hit;
  logic in_set;
  logic out_set;
  logic pop;
  logic load;
  logic [7:0] status_byte;

  host_fifo_if #(.WIDTH(DATA_W)) out_q ();

  // Output words wait here until the host empties the output buffer
  sync_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) out_fifo (
    .clock(clock),
    .rst(rst),
    .q(out_q)
  );

  // Control fields
  assign wide = st.ctrl[host_port_pkg::CTRL_WIDTH_BIT];
  assign style_rw = st.ctrl[host_port_pkg::CTRL_STYLE_BIT];
  assign bsel_pol = st.ctrl[host_port_pkg::CTRL_BSEL_POL_BIT];

  // Strobe decode; chip select gates every style
  always_comb begin
    strobe_on = host_single_strobe == st.ctrl[host_port_pkg::CTRL_STROBE_POL_BIT];
    if (style_rw) begin
      wr_act = !host_chip_select_n && strobe_on && !host_read_write_n;
      rd_act = !host_chip_select_n && strobe_on && host_read_write_n;
    end else begin
      wr_act = !host_chip_select_n && !host_input_strobe_n;
      rd_act = !host_chip_select_n && !host_output_strobe_n;
    end
  end

  // Byte lane and completion decode
  assign lane_low = byte_select == bsel_pol;
  assign wr_done = st.wr_prev && !wr_act;
  assign rd_done = st.rd_prev && !rd_act;
  assign data_hit = !st.lat_status && (st.lat_low || wide);
  assign last_byte = wide ? (st.lat_low == bsel_pol) : 1'b1;
  assign in_set = wr_done && data_hit && last_byte;
  assign out_set = rd_done && data_hit && last_byte;

  // Core handshakes with the buffers
  assign pop = core_in_ready && st.ifull;
  assign load = st.oempty && out_q.pop_valid && !out_set;
  assign out_q.pop_ready = load;
  assign out_q.push_valid = core_out_valid;
  assign out_q.push_data = core_out_data;
  assign core_out_ready = out_q.push_ready;

  // Status byte with optional empty inversion
  always_comb begin
    status_byte = host_port_pkg::BYTE_RESET;
    status_byte[host_port_pkg::STAT_IFULL_BIT] = st.ifull;
    status_byte[host_port_pkg::STAT_OEMPTY_BIT] =
      st.oempty ^ st.ctrl[host_port_pkg::CTRL_EMPTY_INV_BIT];
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.wr_prev = wr_act;
    next_st.rd_prev = rd_act;
    // Target and data held through the access
    if (wr_act || rd_act) begin
      next_st.lat_status = status_select;
      next_st.lat_low = lane_low;
      next_st.lat_data = host_data_in;
    end
    // Host write commits on the strobe's trailing edge
    if (wr_done && data_hit) begin
      if (st.lat_low) begin
        next_st.ibuf[7:0] = st.lat_data;
      end else begin
        next_st.ibuf[15:8] = st.lat_data;
      end
    end
    // Set wins over the core's clear
    if (in_set) begin
      next_st.ifull = 1'b1;
    end else if (pop) begin
      next_st.ifull = 1'b0;
    end
    if (out_set) begin
      next_st.oempty = 1'b1;
    end else if (load) begin
      next_st.oempty = 1'b0;
      next_st.obuf = out_q.pop_data;
    end
    // Read data: status, low byte, high byte or zero for reserved codes
    if (status_select && lane_low) begin
      next_st.pin_data = status_byte;
    end else if (!status_select && lane_low) begin
      next_st.pin_data = st.obuf[7:0];
    end else if (!status_select && wide) begin
      next_st.pin_data = st.obuf[15:8];
    end else begin
      next_st.pin_data = host_port_pkg::BYTE_RESET;
    end
    next_st.pin_oe_n = !rd_act;
    // Flag pins with polarity and OR option
    next_st.ifull_pin = (st.ctrl[host_port_pkg::CTRL_FLAG_OR_BIT] ?
      (st.ifull || st.oempty) : st.ifull) ^ st.ctrl[host_port_pkg::CTRL_FLAG_POL_BIT];
    next_st.oempty_pin = st.oempty ^ st.ctrl[host_port_pkg::CTRL_FLAG_POL_BIT];
    // Strobe assertion interrupts
    next_st.irq_in = wr_act && !st.wr_prev && irq_enable[host_port_pkg::IRQ_IN_BIT];
    next_st.irq_out = rd_act && !st.rd_prev && irq_enable[host_port_pkg::IRQ_OUT_BIT];
    if (ctrl_write) begin
      next_st.ctrl = ctrl_wdata;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= host_port_pkg::CTRL_RESET;
      st.ifull <= host_port_pkg::IFULL_RESET;
      st.oempty <= host_port_pkg::OEMPTY_RESET;
      st.pin_oe_n <= 1'b1;
      st.ifull_pin <= host_port_pkg::IFULL_RESET;
      st.oempty_pin <= host_port_pkg::OEMPTY_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from the state register
  assign host_data_out = st.pin_data;
  assign host_data_oe_n = st.pin_oe_n;
  assign input_full_pin = st.ifull_pin;
  assign output_empty_pin = st.oempty_pin;
  assign ctrl_rdata = st.ctrl;
  assign core_in_valid = st.ifull;
  assign core_in_data = st.ibuf;
  assign input_strobe_irq = st.irq_in;
  assign output_strobe_irq = st.irq_out;

  // Checks on the port's behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_low_write_8;
    wr_done && !st.lat_status && st.lat_low && !wide;
  endsequence

  sequence s_first_byte_16;
    wr_done && !st.lat_status && wide && (st.lat_low != bsel_pol) && !st.ifull;
  endsequence

  sequence s_cs_idle;
    host_chip_select_n [*2];
  endsequence

  sequence s_low_read_8;
    rd_done && !st.lat_status && st.lat_low && !wide;
  endsequence

  // Chip select high for two cycles sets no flag
  property p_cs_ignore;
    s_cs_idle |=> !$rose(st.ifull) && !$rose(st.oempty) && st.pin_oe_n;
  endproperty
  a_cs_ignore: assert property (p_cs_ignore)
    else $error("strobe honoured under chip select high");

  // Pins are driven only after a read strobe
  property p_drive_only_on_read;
    !host_data_oe_n |-> $past(rd_act);
  endproperty
  a_drive_only_on_read: assert property (p_drive_only_on_read)
    else $error("data pins driven without read");

  // Status byte layout with empty inversion
  property p_status_byte;
    rd_act && status_select && lane_low |=> host_data_out ==
      {6'h00, $past(st.ifull), $past(st.oempty ^ st.ctrl[host_port_pkg::CTRL_EMPTY_INV_BIT])};
  endproperty
  a_status_byte: assert property (p_status_byte) else $error("status byte wrong");

  // 8-bit low byte write fills the input buffer
  property p_write_8;
    s_low_write_8 |=> st.ifull && st.ibuf[7:0] == $past(st.lat_data);
  endproperty
  a_write_8: assert property (p_write_8) else $error("8-bit write did not set full");

  // First byte of a 16-bit pair leaves the flag clear
  property p_first_byte_16;
    s_first_byte_16 |=> !st.ifull;
  endproperty
  a_first_byte_16: assert property (p_first_byte_16)
    else $error("flag set on first byte");

  // Core read clears the full flag
  property p_pop_clear;
    pop && !in_set |=> !st.ifull ##1 !core_in_valid || $past(in_set);
  endproperty
  a_pop_clear: assert property (p_pop_clear)
    else $error("core read did not clear full");

  // FIFO word loads the output buffer and clears empty
  property p_load_clear;
    load |=> !st.oempty && st.obuf == $past(out_q.pop_data);
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("output load failed");

  // Empty pin follows flag and polarity
  property p_empty_pin;
    ##1 1'b1 |-> output_empty_pin ==
      $past(st.oempty ^ st.ctrl[host_port_pkg::CTRL_FLAG_POL_BIT]);
  endproperty
  a_empty_pin: assert property (p_empty_pin) else $error("empty pin wrong");

  // OR option drives full pin from either flag
  property p_flag_or;
    st.ctrl[host_port_pkg::CTRL_FLAG_OR_BIT] && !st.ctrl[host_port_pkg::CTRL_FLAG_POL_BIT]
      && st.oempty |=> input_full_pin;
  endproperty
  a_flag_or: assert property (p_flag_or) else $error("full pin missed OR");

  // Enabled strobe assertion raises interrupt next cycle
  property p_irq_in;
    wr_act && !st.wr_prev && irq_enable[host_port_pkg::IRQ_IN_BIT] |=> input_strobe_irq ##1
      (!input_strobe_irq || $past(wr_act && !st.wr_prev));
  endproperty
  a_irq_in: assert property (p_irq_in) else $error("input strobe interrupt missing");

  // Enabled read strobe assertion raises interrupt next cycle
  property p_irq_out;
    rd_act && !st.rd_prev && irq_enable[host_port_pkg::IRQ_OUT_BIT] |=> output_strobe_irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("output strobe interrupt missing");

  // 8-bit low byte read completion sets output empty
  property p_read_8;
    s_low_read_8 |=> st.oempty;
  endproperty
  a_read_8: assert property (p_read_8) else $error("8-bit read did not set empty");

  // Closing byte of a 16-bit pair sets the full flag
  property p_last_byte_16;
    wr_done && !st.lat_status && wide && (st.lat_low == bsel_pol) |=> st.ifull;
  endproperty
  a_last_byte_16: assert property (p_last_byte_16)
    else $error("flag not set on last byte");

  // Reserved codes read back as zero
  property p_reserved_read;
    rd_act && !lane_low && !(wide && !status_select) |=>
      host_data_out == host_port_pkg::BYTE_RESET;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved read not zero");

  // Data pins released one cycle after the read strobe drops
  property p_oe_release;
    rd_done |=> host_data_oe_n;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("data pins held after read");
endmodule
`default_nettype wire

// file: dv/host_model.sv
// Behavioural host that drives the port's strobes, selects and write data
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Device data pins
  input wire logic [7:0] dev_data,
  input wire logic dev_oe_n,
  // Host strobes and selects
  output logic cs_n,
  output logic ids_n,
  output logic ods_n,
  output logic ds,
  output logic rw_n,
  output logic bsel,
  output logic ssel,
  output logic [7:0] dout
);
  logic cs_idle = 1'b0;
  // Idle bus, chip select tied low between accesses
  initial begin
    cs_n = 1'b0;
    ids_n = 1'b1;
    ods_n = 1'b1;
    ds = 1'b0;
    rw_n = 1'b1;
    bsel = 1'b0;
    ssel = 1'b0;
    dout = 8'h00;
  end
  // One access: two active cycles, then a three cycle gap
  task automatic xfer(input logic sty, input logic pol, input logic wr, input logic bs,
                      input logic ss, input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clock);
    cs_n = cs_idle;
    bsel = bs;
    ssel = ss;
    dout = wr ? wd : ~dout;
    rw_n = ~wr;
    // Host makes every strobe
    if (sty) ds = pol;
    else if (wr) ids_n = 1'b0;
    else ods_n = 1'b0;
    repeat (2) @(negedge clock);
    rd = dev_oe_n ? 8'hZZ : dev_data;
    ids_n = 1'b1;
    ods_n = 1'b1;
    ds = ~pol;
    dout = ~dout; // No stale value after release
    cs_n = 1'b0;
    repeat (3) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// file: dv/tb_host_parallel_port.sv
// Self-checking bench for the parallel host byte port
`timescale 1ns/1ps
`default_nettype none
module tb_host_parallel_port;
  logic clock, rst, cs_n, ids_n, ods_n, ds, rw_n, bsel, ssel, ok;
  logic [7:0] hdin, hdout, rd, b0, b1;
  logic oe_n, full_pin, empty_pin, ctrl_write, in_valid, in_ready, out_valid, out_ready;
  logic [15:0] ctrl_wdata, ctrl_rdata, in_data, out_data, w;
  logic [1:0] irq_en;
  logic irq_in, irq_out;
  int errors = 0;
  int n_tests = 0;
  int irq_in_n = 0;
  int irq_out_n = 0;
  int n0;
  logic [31:0] lfsr = 32'h263D;
  logic [15:0] outq[$];
  host_parallel_port host_parallel_port_inst (.clock(clock), .rst(rst),
    .host_chip_select_n(cs_n), .host_input_strobe_n(ids_n), .host_output_strobe_n(ods_n),
    .host_single_strobe(ds), .host_read_write_n(rw_n), .byte_select(bsel),
    .status_select(ssel), .host_data_in(hdin), .host_data_out(hdout),
    .host_data_oe_n(oe_n), .input_full_pin(full_pin), .output_empty_pin(empty_pin),
    .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .core_in_valid(in_valid), .core_in_ready(in_ready), .core_in_data(in_data),
    .core_out_valid(out_valid), .core_out_ready(out_ready), .core_out_data(out_data),
    .irq_enable(irq_en), .input_strobe_irq(irq_in), .output_strobe_irq(irq_out));
  host_model host_model_inst (.clock(clock), .dev_data(hdout), .dev_oe_n(oe_n),
    .cs_n(cs_n), .ids_n(ids_n), .ods_n(ods_n), .ds(ds), .rw_n(rw_n), .bsel(bsel),
    .ssel(ssel), .dout(hdin));
  // Clock and interrupt pulse counters
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) begin
    if (irq_in === 1'b1) irq_in_n++;
    if (irq_out === 1'b1) irq_out_n++;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic void rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  endfunction
  task automatic set_ctrl(input logic [15:0] v);
    @(negedge clock);
    ctrl_write = 1'b1;
    ctrl_wdata = v;
    @(negedge clock);
    ctrl_write = 1'b0;
    @(negedge clock);
    chk("ctrl", ctrl_rdata, v);
  endtask
  task automatic hx(input logic wr, input logic bs, input logic ss, input logic [7:0] d);
    host_model_inst.xfer(ctrl_wdata[1], ctrl_wdata[2], wr, bs, ss, d, rd);
  endtask
  task automatic pop();
    @(negedge clock);
    in_ready = 1'b1;
    @(negedge clock);
    in_ready = 1'b0;
    repeat (2) @(negedge clock);
    chk("in_valid", in_valid, 1'b0);
  endtask
  task automatic push(input logic [15:0] v, output logic acc);
    @(negedge clock);
    acc = (out_ready === 1'b1);
    out_valid = acc;
    out_data = v;
    @(negedge clock);
    out_valid = 1'b0;
    if (acc) outq.push_back(v);
  endtask
  // Watchdog
  initial begin
    #500000;
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ctrl_write = 1'b0;
    ctrl_wdata = 16'h0000;
    in_ready = 1'b0;
    out_valid = 1'b0;
    out_data = 16'h0000;
    irq_en = 2'b11;
    repeat (4) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    chk("empty_pin", empty_pin, 1'b1);
    chk("full_pin", full_pin, 1'b0);
    chk("ctrl", ctrl_rdata, 16'h0000);
    chk("oe_n", oe_n, 1'b1);
    $display("test reset done");
    rnd();
    hx(1'b1, 1'b0, 1'b0, lfsr[7:0]);
    chk("in_data", in_data[7:0], lfsr[7:0]);
    chk("in_valid", in_valid, 1'b1);
    chk("full_pin", full_pin, 1'b1);
    hx(1'b0, 1'b0, 1'b1, 8'h00);
    chk("status", rd, 8'h03);
    chk("irq", irq_in_n + irq_out_n * 4, 5);
    pop();
    hx(1'b0, 1'b0, 1'b1, 8'h00);
    chk("status", rd, 8'h01);
    host_model_inst.cs_idle = 1'b1;
    hx(1'b1, 1'b0, 1'b0, 8'hA5);
    host_model_inst.cs_idle = 1'b0;
    chk("cs ignored", in_valid, 1'b0);
    chk("cs irq", irq_in_n, 1);
    hx(1'b0, 1'b1, 1'b0, 8'h00);
    chk("reserved", rd, 8'h00);
    hx(1'b1, 1'b1, 1'b0, 8'h5A);
    chk("reserved wr", in_valid, 1'b0);
    $display("test 8-bit done");
    for (int p = 0; p < 2; p++) begin
      set_ctrl(16'h0001 | (p << 3));
      rnd();
      hx(1'b1, 1'b0, 1'b0, lfsr[7:0]);
      chk("first byte", in_valid, 1'b0);
      hx(1'b1, 1'b1, 1'b0, lfsr[15:8]);
      w = p ? {lfsr[7:0], lfsr[15:8]} : lfsr[15:0];
      chk("word", in_data, w);
      chk("in_valid", in_valid, 1'b1);
      pop();
      rnd();
      push(lfsr[15:0], ok);
      outq.delete();
      repeat (5) @(negedge clock);
      chk("empty_pin", empty_pin, 1'b0);
      hx(1'b0, 1'b0, 1'b0, 8'h00);
      b0 = rd;
      chk("empty mid", empty_pin, 1'b0);
      hx(1'b0, 1'b1, 1'b0, 8'h00);
      b1 = rd;
      w = p ? {b0, b1} : {b1, b0};
      chk("read word", w, lfsr[15:0]);
      chk("empty_pin", empty_pin, 1'b1);
    end
    $display("test 16-bit done");
    set_ctrl(16'h0000);
    for (int s = 0; s < 2; s++) begin
      @(negedge clock) host_model_inst.ds = ~s[0];
      set_ctrl(16'h0002 | (s << 2));
      rnd();
      hx(1'b1, 1'b0, 1'b0, lfsr[7:0]);
      chk("single strobe", in_data[7:0], lfsr[7:0]);
      chk("in_valid", in_valid, 1'b1);
      pop();
      set_ctrl(16'h0000);
    end
    $display("test strobe style done");
    set_ctrl(16'h0010);
    @(negedge clock);
    chk("inv empty_pin", empty_pin, 1'b0);
    chk("inv full_pin", full_pin, 1'b1);
    set_ctrl(16'h0020);
    @(negedge clock);
    chk("or full_pin", full_pin, 1'b1);
    set_ctrl(16'h0080);
    hx(1'b0, 1'b0, 1'b1, 8'h00);
    chk("status inv", rd, 8'h00);
    chk("empty_pin", empty_pin, 1'b1);
    $display("test flag options done");
    set_ctrl(16'h0000);
    irq_en = 2'b00;
    n0 = irq_out_n;
    for (int i = 0; i < 12; i++) begin
      rnd();
      push(lfsr[15:0], ok);
    end
    chk("accepted", outq.size(), 9);
    chk("out_ready", out_ready, 1'b0);
    while (outq.size() > 0) begin
      w = outq.pop_front();
      hx(1'b0, 1'b0, 1'b0, 8'h00);
      chk("drain", rd, w[7:0]);
    end
    chk("empty_pin", empty_pin, 1'b1);
    chk("irq off", irq_out_n, n0);
    $display("test buffer done");
    end_of_test();
  end
endmodule
`default_nettype wire
